// ===== slpc_defs.svh
// Register map, field values, reset values and limits of the lane PRBS checker
`ifndef SLPC_DEFS_SVH
`define SLPC_DEFS_SVH
// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define SLPC_ADDR_EN    12'h315
`define SLPC_ADDR_CTRL  12'h316
`define SLPC_ADDR_THR_L 12'h317
`define SLPC_ADDR_THR_M 12'h318
`define SLPC_ADDR_THR_H 12'h319
`define SLPC_ADDR_CNT_L 12'h31A
`define SLPC_ADDR_CNT_M 12'h31B
`define SLPC_ADDR_CNT_H 12'h31C
`define SLPC_ADDR_PASS  12'h31D
// ------------------------------------------------------------
// Byte fields of the 24-bit threshold and count
// ------------------------------------------------------------
`define SLPC_LO  7:0
`define SLPC_MID 15:8
`define SLPC_HI  23:16
// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define SLPC_EN_RST   8'h00
`define SLPC_CTRL_RST 8'h00
`define SLPC_THR_RST  24'h000000
`define SLPC_CNT_RST  24'h000000
`define SLPC_BYTE_0   8'h00
`define SLPC_HIST_RST 31'h00000000
`define SLPC_WARM_RST 5'h00
// ------------------------------------------------------------
// Pattern codes and feedback taps (bit k is k+1 bits ago)
// ------------------------------------------------------------
`define SLPC_PAT_PRBS7  2'h0
`define SLPC_PAT_PRBS15 2'h1
`define SLPC_PAT_PRBS31 2'h2
`define SLPC_P7_A  6
`define SLPC_P7_B  5
`define SLPC_P15_A 14
`define SLPC_P15_B 13
`define SLPC_P31_A 30
`define SLPC_P31_B 27
// ------------------------------------------------------------
// Sizes and limits
// ------------------------------------------------------------
`define SLPC_LANES     8
`define SLPC_HIST_W    31
`define SLPC_SYNC_BITS 5'h1F
`define SLPC_WARM_ONE  5'h01
`define SLPC_CNT_MAX   24'hFFFFFF
`define SLPC_CNT_ONE   24'h000001
`endif

// ===== slpc_pkg.sv
// Types shared by the lane PRBS checker
`include "slpc_defs.svh"
package slpc_pkg;
  // Expected pattern
  typedef enum logic [1:0] {
    SLPC_PRBS7  = `SLPC_PAT_PRBS7,
    SLPC_PRBS15 = `SLPC_PAT_PRBS15,
    SLPC_PRBS31 = `SLPC_PAT_PRBS31
  } slpc_pat_type;
  // Control register layout, MSB first
  typedef struct packed {
    logic         rsvd;
    logic [2:0]   lane_sel;
    slpc_pat_type pattern;
    logic         start;
    logic         test_reset;
  } slpc_ctrl_type;
  // Register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
  } slpc_reg_req_type;
  // One received bit per lane with its qualifier
  typedef struct packed {
    logic [7:0] valid;
    logic [7:0] bits;
  } slpc_rx_type;
  // Run control
  typedef enum logic {SLPC_IDLE, SLPC_RUN} slpc_state_type;
endpackage

// ===== slpc_lane_prbs_checker.sv
// Eight-lane PRBS bit error checker with its register file and checks
`timescale 1ns/1ps
`include "slpc_defs.svh"
// ------------------------------------------------------------
// Contract
// (R1) Each lane is checked on its own, with no need for an established link.
// (R2) Pattern selector 00 picks PRBS7, 01 PRBS15 and 10 PRBS31.
// (R3) The checker locks onto the incoming sequence by itself before counting errors.
// (R4) Bit n of the lane enable register turns checking on for lane n, any mix at once.
// (R5) Software pulses the test reset bit, which clears checker state, counts and pass flags.
// (R6) A 24-bit error threshold is held in three byte registers.
// (R7) A test is launched only by a rising edge of the start bit.
// (R8) Software runs the test for about 500 ms and stops it by clearing the start bit.
// (R9) One pass bit per lane is reported, 1 for pass and 0 for fail.
// (R10) A three-bit selector picks which lane count is shown in three byte registers.
// (R11) Each lane count saturates at all ones, meaning the maximum was exceeded.
// (R12) The far end already sends the chosen pattern before the checker is started.
// (R13) Counts and pass flags freeze when the test stops, until a reset pulse or start edge.
// ------------------------------------------------------------
module slpc_lane_prbs_checker (
  // Clock and reset
  input  logic                      clk_sys,
  input  logic                      rstn,
  // Register port
  input  slpc_pkg::slpc_reg_req_type reg_req,
  output logic [7:0]                reg_rdata,
  // Receive lanes
  input  slpc_pkg::slpc_rx_type     rx,
  // Status
  output logic                      test_running
);
  import slpc_pkg::*;

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [7:0]             en_q;
  slpc_ctrl_type          ctrl_q;
  logic [23:0]            thr_q;
  logic [7:0]             rdata_q;
  logic                   start_prev_q;
  slpc_state_type         state_q;
  slpc_state_type         state_d;
  logic [7:0]             pass_q;
  logic [30:0]            hist_q [`SLPC_LANES];
  logic [4:0]             warm_q [`SLPC_LANES];
  logic [23:0]            cnt_q  [`SLPC_LANES];
  logic [7:0]             pred;
  logic [7:0]             synced;
  logic [7:0]             mism;
  logic [7:0]             bump;

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  wire wr_en    = reg_req.wr && (reg_req.addr == `SLPC_ADDR_EN);
  wire wr_ctrl  = reg_req.wr && (reg_req.addr == `SLPC_ADDR_CTRL);
  wire wr_thr_l = reg_req.wr && (reg_req.addr == `SLPC_ADDR_THR_L);
  wire wr_thr_m = reg_req.wr && (reg_req.addr == `SLPC_ADDR_THR_M);
  wire wr_thr_h = reg_req.wr && (reg_req.addr == `SLPC_ADDR_THR_H);
  // Reserved control bit is dropped on write so it reads as zero
  wire slpc_ctrl_type ctrl_raw = slpc_ctrl_type'(reg_req.wdata);
  wire slpc_ctrl_type ctrl_wr  = '{rsvd: 1'b0,
                                   lane_sel: ctrl_raw.lane_sel,
                                   pattern: ctrl_raw.pattern,
                                   start: ctrl_raw.start,
                                   test_reset: ctrl_raw.test_reset};

  // Start edge and clear; a held reset bit keeps counts, pass flags, lock and history cleared
  wire start_rise = ctrl_q.start && !start_prev_q;              // R7
  wire clr        = ctrl_q.test_reset || start_rise;            // R5
  wire running    = (state_q == SLPC_RUN);

  // Count readback for the selected lane
  wire [23:0] sel_cnt    = cnt_q[ctrl_q.lane_sel];              // R10
  wire [7:0]  sel_cnt_lo = sel_cnt[`SLPC_LO];

  // Read mux; unmapped offsets read as zero
  wire [7:0] rd_mux =
    (reg_req.addr == `SLPC_ADDR_EN)    ? en_q :
    (reg_req.addr == `SLPC_ADDR_CTRL)  ? ctrl_q :
    (reg_req.addr == `SLPC_ADDR_THR_L) ? thr_q[`SLPC_LO] :
    (reg_req.addr == `SLPC_ADDR_THR_M) ? thr_q[`SLPC_MID] :
    (reg_req.addr == `SLPC_ADDR_THR_H) ? thr_q[`SLPC_HI] :
    (reg_req.addr == `SLPC_ADDR_CNT_L) ? sel_cnt[`SLPC_LO] :
    (reg_req.addr == `SLPC_ADDR_CNT_M) ? sel_cnt[`SLPC_MID] :
    (reg_req.addr == `SLPC_ADDR_CNT_H) ? sel_cnt[`SLPC_HI] :
    (reg_req.addr == `SLPC_ADDR_PASS)  ? pass_q :
    `SLPC_BYTE_0;

  assign reg_rdata    = rdata_q;
  assign test_running = running;

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  // Lane enables and control
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      en_q   <= `SLPC_EN_RST;
      ctrl_q <= `SLPC_CTRL_RST;
    end else begin
      if (wr_en) en_q <= reg_req.wdata;                         // R4
      if (wr_ctrl) ctrl_q <= ctrl_wr;
    end
  end

  // Threshold bytes; may be changed at any time, used live
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      thr_q <= `SLPC_THR_RST;
    end else begin
      if (wr_thr_l) thr_q[`SLPC_LO]  <= reg_req.wdata;          // R6
      if (wr_thr_m) thr_q[`SLPC_MID] <= reg_req.wdata;          // R6
      if (wr_thr_h) thr_q[`SLPC_HI]  <= reg_req.wdata;          // R6
    end
  end

  // Registered read data, one cycle behind the address
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= `SLPC_BYTE_0;
    end else begin
      rdata_q <= rd_mux;
    end
  end

  // ------------------------------------------------------------
  // Run control
  // ------------------------------------------------------------
  // Stopping only needs the level; launching needs a fresh edge
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SLPC_IDLE: if (start_rise && !ctrl_q.test_reset) state_d = SLPC_RUN; // R7
      SLPC_RUN:  if (!ctrl_q.start || ctrl_q.test_reset) state_d = SLPC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q      <= SLPC_IDLE;
      start_prev_q <= 1'b0;
    end else begin
      state_q      <= state_d;
      start_prev_q <= ctrl_q.start;
    end
  end

  // Pass flags follow the counts only during a run, so they hold for readback after it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pass_q <= `SLPC_BYTE_0;
    end else if (clr) begin
      pass_q <= `SLPC_BYTE_0;                                   // R5
    end else if (running) begin                                 // R13
      for (int n = 0; n < `SLPC_LANES; n++) begin
        pass_q[n] <= en_q[n] && (cnt_q[n] <= thr_q);            // R9
      end
    end
  end

  // ------------------------------------------------------------
  // Pattern prediction
  // ------------------------------------------------------------
  // Feedback from the received history; code 11 falls back to PRBS7
  function automatic logic pred_bit(input slpc_pat_type p, input logic [30:0] h);
    logic b;
    b = 1'b0;
    unique case (p)
      SLPC_PRBS7:  b = h[`SLPC_P7_A]  ^ h[`SLPC_P7_B];
      SLPC_PRBS15: b = h[`SLPC_P15_A] ^ h[`SLPC_P15_B];
      SLPC_PRBS31: b = h[`SLPC_P31_A] ^ h[`SLPC_P31_B];
      default:     b = h[`SLPC_P7_A]  ^ h[`SLPC_P7_B];
    endcase
    return b;
  endfunction

  // ------------------------------------------------------------
  // Per-lane checkers
  // ------------------------------------------------------------
  // The history is fed from the line itself, so a single line error is seen
  // up to three times (at the bit and at both taps); the count is of mismatches
  for (genvar n = 0; n < `SLPC_LANES; n++) begin : g_lane
    assign pred[n]   = pred_bit(ctrl_q.pattern, hist_q[n]);     // R2
    assign synced[n] = (warm_q[n] == `SLPC_SYNC_BITS);          // R3
    assign mism[n]   = rx.valid[n] && synced[n] && (rx.bits[n] != pred[n]);
    assign bump[n]   = running && en_q[n] && mism[n] && (cnt_q[n] != `SLPC_CNT_MAX);

    // History shifts on every valid bit unless the test reset bit is set, link state does not matter
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        hist_q[n] <= `SLPC_HIST_RST;
      end else if (ctrl_q.test_reset) begin
        hist_q[n] <= `SLPC_HIST_RST;                            // R5
      end else if (rx.valid[n]) begin
        hist_q[n] <= {hist_q[n][`SLPC_HIST_W-2:0], rx.bits[n]}; // R1
      end
    end

    // Lock after a full history of received bits
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        warm_q[n] <= `SLPC_WARM_RST;
      end else if (clr) begin
        warm_q[n] <= `SLPC_WARM_RST;                            // R3
      end else if (rx.valid[n] && !synced[n]) begin
        warm_q[n] <= warm_q[n] + `SLPC_WARM_ONE;
      end
    end

    // Saturating error count, only enabled lanes during a run
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        cnt_q[n] <= `SLPC_CNT_RST;
      end else if (clr) begin
        cnt_q[n] <= `SLPC_CNT_RST;                              // R5
      end else if (bump[n]) begin
        cnt_q[n] <= cnt_q[n] + `SLPC_CNT_ONE;                   // R11
      end
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_pat15_count;
    @(posedge clk_sys) disable iff (!rstn)
    (running && !clr && en_q[1] && synced[1] && rx.valid[1] && ctrl_q.pattern == SLPC_PRBS15 &&
     rx.bits[1] != (hist_q[1][`SLPC_P15_A] ^ hist_q[1][`SLPC_P15_B]) && cnt_q[1] != `SLPC_CNT_MAX)
    |=> cnt_q[1] == $past(cnt_q[1]) + `SLPC_CNT_ONE;
  endproperty
  a_pat15_count: assert property (p_pat15_count) else $error("PRBS15 mismatch not counted"); // R2

  property p_no_count_unlocked;
    @(posedge clk_sys) disable iff (!rstn)
    (!synced[0] && !clr) |=> $stable(cnt_q[0]);
  endproperty
  a_no_count_unlocked: assert property (p_no_count_unlocked) else $error("Count moved before lock"); // R3

  property p_lane_off;
    @(posedge clk_sys) disable iff (!rstn)
    (!en_q[0] && !clr) |=> $stable(cnt_q[0]);
  endproperty
  a_lane_off: assert property (p_lane_off) else $error("Disabled lane counted"); // R4

  property p_test_reset;
    @(posedge clk_sys) disable iff (!rstn)
    ctrl_q.test_reset |=> (cnt_q[0] == `SLPC_CNT_RST) && (pass_q == `SLPC_BYTE_0) && !running;
  endproperty
  a_test_reset: assert property (p_test_reset) else $error("Test reset did not clear"); // R5

  property p_thr_high;
    @(posedge clk_sys) disable iff (!rstn)
    wr_thr_h |=> thr_q[`SLPC_HI] == $past(reg_req.wdata);
  endproperty
  a_thr_high: assert property (p_thr_high) else $error("Threshold high byte not stored"); // R6

  property p_launch;
    @(posedge clk_sys) disable iff (!rstn)
    (!running && !start_rise) |=> !running;
  endproperty
  a_launch: assert property (p_launch) else $error("Run began without start edge"); // R7

  property p_pass_flag;
    @(posedge clk_sys) disable iff (!rstn)
    (running && !clr) |=> pass_q[2] == ($past(en_q[2]) && ($past(cnt_q[2]) <= $past(thr_q)));
  endproperty
  a_pass_flag: assert property (p_pass_flag) else $error("Pass flag wrong"); // R9

  property p_count_read;
    @(posedge clk_sys) disable iff (!rstn)
    (reg_req.addr == `SLPC_ADDR_CNT_L) |=> reg_rdata == $past(sel_cnt_lo);
  endproperty
  a_count_read: assert property (p_count_read) else $error("Selected count readback wrong"); // R10

  property p_saturate;
    @(posedge clk_sys) disable iff (!rstn)
    (cnt_q[0] == `SLPC_CNT_MAX && !clr) |=> cnt_q[0] == `SLPC_CNT_MAX;
  endproperty
  a_saturate: assert property (p_saturate) else $error("Count wrapped past all ones"); // R11

  property p_freeze;
    @(posedge clk_sys) disable iff (!rstn)
    (!running && !clr) |=> $stable(pass_q) && $stable(cnt_q[3]);
  endproperty
  a_freeze: assert property (p_freeze) else $error("Results moved while stopped"); // R13

  property p_stop;
    @(posedge clk_sys) disable iff (!rstn)
    (running && !ctrl_q.start) |=> !running;
  endproperty
  a_stop: assert property (p_stop) else $error("Run went on after start was cleared"); // R8

  property p_relock;
    @(posedge clk_sys) disable iff (!rstn)
    clr |=> !synced[0];
  endproperty
  a_relock: assert property (p_relock) else $error("Lock survived a clear"); // R3

  property p_hist_shift;
    @(posedge clk_sys) disable iff (!rstn)
    (rx.valid[5] && !ctrl_q.test_reset) |=> hist_q[5][0] == $past(rx.bits[5]);
  endproperty
  a_hist_shift: assert property (p_hist_shift) else $error("Lane history did not take the bit"); // R1

endmodule

// ===== slpc_prbs_tx.sv
// Far-end PRBS source for eight lanes, with line error injection
`timescale 1ns/1ps
`include "slpc_defs.svh"
module slpc_prbs_tx (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  // Control from the bench
  input  wire logic [1:0]       pat,
  input  wire logic [7:0]       go,
  input  wire logic [7:0]       flip,
  // Lanes toward the checker
  output slpc_pkg::slpc_rx_type rx
);
  import slpc_pkg::*;
  logic [30:0] hist_q [8];
  logic [7:0]  nb;
  // ------------------------------------------------------------
  // Generator feedback
  // ------------------------------------------------------------
  // Next clean bit of each lane, code 3 falls back to the short pattern
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      case (pat)
        2'h1:    nb[n] = hist_q[n][`SLPC_P15_A] ^ hist_q[n][`SLPC_P15_B];
        2'h2:    nb[n] = hist_q[n][`SLPC_P31_A] ^ hist_q[n][`SLPC_P31_B];
        default: nb[n] = hist_q[n][`SLPC_P7_A] ^ hist_q[n][`SLPC_P7_B];
      endcase
    end
  end
  // Line errors flip the sent bit only, the generator itself stays clean
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rx <= '0;
      for (int n = 0; n < 8; n++) begin
        hist_q[n] <= 31'h5A5A5A5 ^ 31'(n);
      end
    end else begin
      rx.valid <= go;
      for (int n = 0; n < 8; n++) begin
        if (go[n]) begin
          rx.bits[n] <= nb[n] ^ flip[n];
          hist_q[n]  <= {hist_q[n][29:0], nb[n]};
        end else begin
          rx.bits[n] <= ~rx.bits[n]; // Idle lane never shows a stale bit
        end
      end
    end
  end
endmodule

// ===== serdes_lane_prbs_checker_tb_top.sv
// Self-checking bench for the eight-lane PRBS checker
`timescale 1ns/1ps
`include "slpc_defs.svh"
module serdes_lane_prbs_checker_tb_top;
  import slpc_pkg::*;
  logic             clk_sys;
  logic             rstn;
  logic             test_running;
  slpc_reg_req_type reg_req;
  slpc_rx_type      rx;
  logic [7:0]       reg_rdata;
  logic [7:0]       go;
  logic [7:0]       flip;
  logic [7:0]       b;
  logic [7:0]       exp_pass;
  logic [1:0]       pat;
  logic             full;
  logic [31:0]      rnd;
  logic [23:0]      got;
  int               err_total;
  int               checks;
  int               cyc;
  int               exp_cnt [8];
  slpc_lane_prbs_checker i_slpc_lane_prbs_checker (.clk_sys(clk_sys), .rstn(rstn), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .rx(rx), .test_running(test_running));
  slpc_prbs_tx i_slpc_prbs_tx (.clk_sys(clk_sys), .rstn(rstn), .pat(pat), .go(go), .flip(flip), .rx(rx));
  // ------------------------------------------------------------
  // Clock, random lane gaps and hang guard
  // ------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Gaps only during setup and locking, so error timing stays exact
  always @(posedge clk_sys) begin
    rnd <= lfsr(rnd);
    go  <= full ? 8'hFF : (rnd[7:0] | rnd[15:8]);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1};
    @(posedge clk_sys);
    reg_req.wr <= 1'b0;
  endtask
  // Address is held two edges so either read latency reading is met
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_req.addr <= a;
    repeat (2) @(posedge clk_sys);
    #1 d = reg_rdata;
  endtask
  task automatic rd24(input logic [11:0] a);
    rd(a, got[7:0]);
    rd(a + 12'h001, got[15:8]);
    rd(a + 12'h002, got[23:16]);
  endtask
  // One full run: setup, lock, inject e[2n+:2] line errors per lane, stop, read back
  task automatic run_case(input logic [1:0] p, input logic [7:0] en, input logic [23:0] thr, input logic [15:0] e);
    pat  <= p;
    full <= 1'b0;
    wr(`SLPC_ADDR_EN, en);
    wr(`SLPC_ADDR_THR_L, thr[7:0]);
    wr(`SLPC_ADDR_THR_M, thr[15:8]);
    wr(`SLPC_ADDR_THR_H, thr[23:16]);
    wr(`SLPC_ADDR_CTRL, {4'h0, p, 2'h1});
    wr(`SLPC_ADDR_CTRL, {4'h0, p, 2'h0});
    rd(`SLPC_ADDR_PASS, b);
    chk("pass after reset", 24'h0, {16'h0, b});
    rd24(`SLPC_ADDR_THR_L);
    chk("threshold", thr, got);
    rd24(`SLPC_ADDR_CNT_L);
    chk("count after reset", 24'h0, got);
    wr(`SLPC_ADDR_CTRL, {4'h0, p, 2'h2});
    #1 chk("running one cycle", 24'h0, {23'h0, test_running});
    @(posedge clk_sys);
    #1 chk("running two cycles", 24'h1, {23'h0, test_running});
    repeat (150) @(posedge clk_sys);
    full <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      repeat (40) @(posedge clk_sys);
      for (int n = 0; n < 8; n++) begin
        flip[n] <= (int'(e[2*n +: 2]) > k);
      end
      @(posedge clk_sys);
      flip <= 8'h00;
    end
    repeat (40) @(posedge clk_sys);
    wr(`SLPC_ADDR_CTRL, {4'h0, p, 2'h2});
    wr(`SLPC_ADDR_CTRL, {4'h0, p, 2'h0});
    #1 chk("stopping one cycle", 24'h1, {23'h0, test_running});
    @(posedge clk_sys);
    #1 chk("stopped", 24'h0, {23'h0, test_running});
    for (int n = 0; n < 8; n++) begin
      exp_cnt[n]  = en[n] ? 3 * int'(e[2*n +: 2]) : 0;
      exp_pass[n] = en[n] && (exp_cnt[n] <= int'(thr));
    end
    rd(`SLPC_ADDR_PASS, b);
    chk("pass flags", {16'h0, exp_pass}, {16'h0, b});
    for (int n = 0; n < 8; n++) begin
      wr(`SLPC_ADDR_CTRL, {1'b0, 3'(n), p, 2'h0});
      rd24(`SLPC_ADDR_CNT_L);
      chk("lane count", 24'(exp_cnt[n]), got);
    end
    // Errors after the stop must not touch the held results
    flip <= 8'hFF;
    @(posedge clk_sys);
    flip <= 8'h00;
    repeat (40) @(posedge clk_sys);
    rd(`SLPC_ADDR_PASS, b);
    chk("held pass", {16'h0, exp_pass}, {16'h0, b});
    rd24(`SLPC_ADDR_CNT_L);
    chk("held count", 24'(exp_cnt[7]), got);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rstn      = 1'b0;
    reg_req   = '0;
    pat       = 2'h0;
    flip      = 8'h00;
    full      = 1'b0;
    go        = 8'h00;
    rnd       = 32'd70265;
    err_total = 0;
    checks    = 0;
    cyc       = 0;
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int a = 'h315; a <= 'h31D; a++) begin
      rd(12'(a), b);
      chk("reset value", 24'h0, {16'h0, b});
    end
    // Unmapped, read-only and reserved places never take a write
    wr(12'h314, 8'hFF);
    rd(12'h314, b);
    chk("unmapped", 24'h0, {16'h0, b});
    wr(`SLPC_ADDR_CNT_L, 8'hFF);
    rd(`SLPC_ADDR_CNT_L, b);
    chk("count read only", 24'h0, {16'h0, b});
    wr(`SLPC_ADDR_CTRL, 8'h80);
    rd(`SLPC_ADDR_CTRL, b);
    chk("reserved bit", 24'h0, {16'h0, b});
    run_case(2'h0, 8'hFF, 24'h000002, 16'h1084);
    run_case(2'h1, 8'h5A, 24'h000003, 16'h4A05);
    run_case(2'h2, 8'h81, 24'h0A0100, 16'h4042);
    finish_test();
  end
endmodule
